/* File: rnghg_core_model.sv */
// consumer model: takes each valid word after a short wait, random only in slow mode
`timescale 1ns/10ps
module rnghg_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // word handshake
  input wire logic word_valid,
  output logic word_ack,
  // pacing
  input wire logic slow
);
  initial word_ack = 1'b0;
  // one-cycle ack pulse; slow mode skips cycles at random
  always @(negedge clk) begin
    if (word_ack || !reset_n) begin
      word_ack <= 1'b0;
    end else if (word_valid === 1'b1 && (!slow || $urandom_range(1) == 1)) begin
      word_ack <= 1'b1;
    end
  end
endmodule : rnghg_core_model

/* File: rnghg_gate.sv */
// output gate of the random number source: health tests and word packing
`timescale 1ns/10ps
module rnghg_gate (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // raw entropy source, asynchronous to clk
  input wire logic raw_bit_in,
  input wire logic raw_stb_in,
  // configuration from the core
  input wire logic enable,
  input wire logic wide_word,
  input wire logic path_hybrid,
  // random word to the core
  output logic [rnghg_pkg::WORD_W_WIDE-1:0] word,
  output logic word_valid,
  input wire logic word_ack,
  // status
  output logic startup_done,
  output logic fail_total,
  output logic fail_stat
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_STARTUP = 4'h2,
    ST_RUN = 4'h4,
    ST_DEAD = 4'h8
  } rnghg_state_e;

  logic rst_meta, rst_n;
  logic bit_m, bit_s, stb_m, stb_s, stb_d;
  rnghg_state_e state, next_state;
  logic [rnghg_pkg::WORD_W_WIDE-1:0] shreg, next_shreg, next_word;
  logic [rnghg_pkg::WCNT_W-1:0] nbits, next_nbits;
  logic next_word_valid, next_fail_total, next_fail_stat, next_startup_done;
  logic stb_rise;
  logic [rnghg_pkg::WCNT_W-1:0] need;
  rnghg_health_if hif ();

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // raw pins pass two flops; the strobe gets a third flop so its second and third copies form the rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_m <= 1'b0;
      bit_s <= 1'b0;
      stb_m <= 1'b0;
      stb_s <= 1'b0;
      stb_d <= 1'b0;
    end else begin
      bit_m <= raw_bit_in;
      bit_s <= bit_m;
      stb_m <= raw_stb_in;
      stb_s <= stb_m;
      stb_d <= stb_s;
    end
  end

  assign stb_rise = stb_s & ~stb_d;
  assign hif.bit_stb = stb_rise && (state != ST_IDLE) && (state != ST_DEAD);
  assign hif.raw_bit = bit_s;
  assign need = wide_word ? rnghg_pkg::WCNT_W'(rnghg_pkg::WORD_W_WIDE)
                          : rnghg_pkg::WCNT_W'(rnghg_pkg::WORD_W_NARROW);

  rnghg_online_test u_test (
    .clk(clk),
    .rst_n(rst_n),
    .hif(hif)
  );

  // sequencing, packing and withholding
  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_nbits = nbits;
    next_word = word;
    next_word_valid = word_valid && !word_ack;
    next_fail_total = fail_total;
    next_fail_stat = fail_stat;
    next_startup_done = startup_done;
    unique case (state)
      ST_IDLE: begin
        if (enable) begin
          next_state = ST_STARTUP;
          next_nbits = '0;
        end
      end
      ST_STARTUP: begin
        // nothing leaves before the first window passes
        if (hif.win_done && hif.win_pass) begin
          next_state = ST_RUN;
          next_startup_done = 1'b1;
        end else if (hif.win_done) begin
          next_fail_stat = 1'b1;
        end
      end
      ST_RUN: begin
        // disable wins over packing, else a word could stand with no startup pass
        if (!enable) begin
          next_state = ST_IDLE;
          next_word_valid = 1'b0;
          next_startup_done = 1'b0;
        end else if (hif.bit_stb) begin
          next_shreg = {shreg[rnghg_pkg::WORD_W_WIDE-2:0], hif.raw_bit};
          next_nbits = nbits + 1'b1;
          if (next_nbits == need) begin
            next_nbits = '0;
            // a word still pending is overwritten; old bits are lost
            next_word = wide_word ? next_shreg
                      : {8'h00, next_shreg[rnghg_pkg::WORD_W_NARROW-1:0]};
            next_word_valid = 1'b1;
          end
        end
        if (hif.win_done && !hif.win_pass) begin
          next_fail_stat = 1'b1;
          // a disable in the same cycle still takes the block to idle
          next_state = enable ? ST_STARTUP : ST_IDLE;
          next_startup_done = 1'b0;
          next_word_valid = 1'b0;
          next_nbits = '0;
        end
      end
      ST_DEAD: begin
        next_word_valid = 1'b0;
      end
      default: next_state = ST_IDLE;
    endcase
    // both paths share the stuck check; a failure drops the pending word too
    if (hif.total_fail) begin
      next_state = ST_DEAD;
      next_fail_total = 1'b1;
      next_word_valid = 1'b0;
      next_startup_done = 1'b0;
    end
  end

  // registers of the sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      shreg <= '0;
      nbits <= '0;
      word <= '0;
      word_valid <= 1'b0;
      fail_total <= 1'b0;
      fail_stat <= 1'b0;
      startup_done <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      nbits <= next_nbits;
      word <= next_word;
      word_valid <= next_word_valid;
      fail_total <= next_fail_total;
      fail_stat <= next_fail_stat;
      startup_done <= next_startup_done;
    end
  end

  // path_hybrid only labels the source; post-processing lives elsewhere
  logic unused_path;
  assign unused_path = path_hybrid;

  // withholding, word-format and sticky-status properties
  a_dead_no_valid: assert property (@(posedge clk) disable iff (!rst_n)
    fail_total |-> !word_valid) else $error("word valid after total failure");
  a_fail_kills_word: assert property (@(posedge clk) disable iff (!rst_n)
    hif.total_fail |=> !word_valid) else $error("word survived failure");
  a_startup_gate: assert property (@(posedge clk) disable iff (!rst_n)
    word_valid |-> startup_done) else $error("word before startup pass");
  a_defect_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_RUN && hif.win_done && !hif.win_pass) |=> !word_valid && fail_stat)
    else $error("defect did not block output");
  a_narrow_word: assert property (@(posedge clk) disable iff (!rst_n)
    (word_valid && !wide_word) |-> word[15:8] == 8'h00)
    else $error("narrow word upper bits set");
  a_total_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    $past(fail_total) |-> fail_total) else $error("total failure cleared");
  a_hybrid_dead: assert property (@(posedge clk) disable iff (!rst_n)
    (path_hybrid && hif.total_fail) |=> state == ST_DEAD)
    else $error("hybrid path not stopped");
  a_stat_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    $past(fail_stat) |-> fail_stat) else $error("defect flag cleared");
  a_dead_stays: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_DEAD |=> state == ST_DEAD)
    else $error("dead state left without reset");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_IDLE |-> !word_valid && !startup_done)
    else $error("word or startup status while idle");
  a_startup_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(startup_done) |-> $past(hif.win_done && hif.win_pass))
    else $error("startup passed without a good window");
  a_ack_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (word_valid && word_ack && !hif.bit_stb) |=> !word_valid)
    else $error("taken word still marked valid");
  // main scenarios for coverage
  c_startup_pass: cover property (@(posedge clk) disable iff (!rst_n) $rose(startup_done));
  c_wide_word: cover property (@(posedge clk) disable iff (!rst_n) word_valid && wide_word);
  c_word_out: cover property (@(posedge clk) disable iff (!rst_n) $rose(word_valid));
  c_total_fail: cover property (@(posedge clk) disable iff (!rst_n) $rose(fail_total));
  c_stat_fail: cover property (@(posedge clk) disable iff (!rst_n) $rose(fail_stat));
endmodule : rnghg_gate

/* File: rnghg_health_if.sv */
// health verdict bundle between online test and output gate
`timescale 1ns/10ps
interface rnghg_health_if;
  logic bit_stb;
  logic raw_bit;
  logic win_done;
  logic win_pass;
  logic total_fail;
  modport tester (input bit_stb, input raw_bit, output win_done, output win_pass,
    output total_fail);
  modport gate (output bit_stb, output raw_bit, input win_done, input win_pass,
    input total_fail);
endinterface : rnghg_health_if

/* File: rnghg_online_test.sv */
// continuous total-failure and statistical test on the raw bit stream
`timescale 1ns/10ps
module rnghg_online_test (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // verdicts
  rnghg_health_if.tester hif
);
  logic [rnghg_pkg::RUN_W-1:0] run_len, next_run_len;
  logic last_bit, next_last_bit;
  logic [rnghg_pkg::WIN_W-1:0] win_cnt, next_win_cnt;
  logic [rnghg_pkg::WIN_W-1:0] ones, next_ones;
  logic done, next_done, pass, next_pass, tfail, next_tfail;

  // run-length stuck detection and windowed ones count, every raw bit
  always_comb begin
    next_run_len = run_len;
    next_last_bit = last_bit;
    next_win_cnt = win_cnt;
    next_ones = ones;
    next_done = 1'b0;
    next_pass = pass;
    next_tfail = 1'b0;
    if (hif.bit_stb) begin
      next_last_bit = hif.raw_bit;
      if (hif.raw_bit == last_bit) begin
        next_run_len = run_len + 1'b1;
        if (run_len >= rnghg_pkg::RUN_W'(rnghg_pkg::STUCK_RUN_MAX - 1)) begin
          next_tfail = 1'b1;
        end
      end else begin
        next_run_len = '0;
      end
      next_ones = ones + rnghg_pkg::WIN_W'(hif.raw_bit);
      next_win_cnt = win_cnt + 1'b1;
      if (win_cnt == rnghg_pkg::WIN_W'(rnghg_pkg::WIN_BITS - 1)) begin
        next_done = 1'b1;
        // ones band is only a coarse screen; entropy per bit is not measured here
        next_pass = (next_ones >= rnghg_pkg::WIN_W'(rnghg_pkg::ONES_MIN)) &&
                    (next_ones <= rnghg_pkg::WIN_W'(rnghg_pkg::ONES_MAX));
        next_win_cnt = '0;
        next_ones = '0;
      end
    end
  end

  // counters and verdict flags register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_len <= '0;
      last_bit <= 1'b0;
      win_cnt <= '0;
      ones <= '0;
      done <= 1'b0;
      pass <= 1'b0;
      tfail <= 1'b0;
    end else begin
      run_len <= next_run_len;
      last_bit <= next_last_bit;
      win_cnt <= next_win_cnt;
      ones <= next_ones;
      done <= next_done;
      pass <= next_pass;
      tfail <= next_tfail;
    end
  end

  assign hif.win_done = done;
  assign hif.win_pass = pass;
  assign hif.total_fail = tfail;

  a_window_period: assert property (@(posedge clk) disable iff (!rst_n)
    done |-> !$past(done)) else $error("window verdict repeated");
endmodule : rnghg_online_test

/* File: rnghg_pkg.sv */
// constants shared by the random number health gate
package rnghg_pkg;
  // word formats
  localparam int WORD_W_NARROW = 8;
  localparam int WORD_W_WIDE = 16;
  // total-failure test: longest run of equal raw bits tolerated
  localparam int STUCK_RUN_MAX = 32;
  // online test window and accepted ones-count band (monobit style)
  localparam int WIN_BITS = 256;
  localparam int ONES_MIN = 96;
  localparam int ONES_MAX = 160;
  // counter widths
  localparam int RUN_W = 6;
  localparam int WIN_W = 9;
  localparam int WCNT_W = 5;
  // path select codes
  localparam logic PATH_TRUE = 1'b0;
  localparam logic PATH_HYBRID = 1'b1;
endpackage : rnghg_pkg

/* File: tb_top.sv */
// self-checking bench for the random number health gate
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic raw_bit_in = 1'b0;
  logic raw_stb_in = 1'b0;
  logic enable = 1'b0;
  logic wide_word = 1'b0;
  logic path_hybrid = 1'b0;
  logic slow = 1'b0;
  logic word_ack;
  logic [rnghg_pkg::WORD_W_WIDE-1:0] word;
  logic word_valid;
  logic startup_done;
  logic fail_total;
  logic fail_stat;
  logic [15:0] exp_q[$];
  logic [15:0] sh = 16'h0000;
  int cnt = 0;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  bit track = 1'b0;
  bit quiet = 1'b0;

  always #5 clk = ~clk;

  rnghg_gate rnghg_gate_inst (.clk(clk), .reset_n(reset_n), .raw_bit_in(raw_bit_in),
    .raw_stb_in(raw_stb_in), .enable(enable), .wide_word(wide_word),
    .path_hybrid(path_hybrid), .word(word), .word_valid(word_valid), .word_ack(word_ack),
    .startup_done(startup_done), .fail_total(fail_total), .fail_stat(fail_stat));
  rnghg_core_model rnghg_core_model_inst (.clk(clk), .reset_n(reset_n),
    .word_valid(word_valid), .word_ack(word_ack), .slow(slow));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // expectation noted before the bit goes out, so it is queued ahead of the word
  task automatic send_bit(input logic b);
    if (track) begin
      sh = {sh[14:0], b};
      cnt++;
      if (cnt == (wide_word ? 16 : 8)) begin
        exp_q.push_back(wide_word ? sh : {8'h00, sh[7:0]});
        cnt = 0;
      end
    end
    raw_bit_in = b;
    raw_stb_in = 1'b1;
    repeat (2) @(negedge clk);
    raw_stb_in = 1'b0;
    repeat (2) @(negedge clk);
  endtask : send_bit

  task automatic send_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
  endtask : send_byte

  // byte plus its complement: 8 ones per 16 bits, runs never past 16
  task automatic send_good(input int pairs);
    logic [7:0] r;
    for (int i = 0; i < pairs; i++) begin
      r = 8'($urandom);
      send_byte(r);
      send_byte(~r);
    end
    repeat (2) @(negedge clk);
  endtask : send_good

  task automatic drain;
    for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(negedge clk);
    check(16'(exp_q.size()), 16'h0000);
    track = 1'b0;
    cnt = 0;
  endtask : drain

  task automatic stuck(input logic b);
    quiet = 1'b1;
    repeat (40) send_bit(b);
    repeat (2) @(negedge clk);
    check({15'h0, fail_total}, 16'h0001);
    quiet = 1'b0;
    send_good(8);
    check({15'h0, word_valid}, 16'h0000);
    check({15'h0, fail_total}, 16'h0001);
  endtask : stuck

  task automatic start(input int m);
    reset_n = 1'b0;
    enable = 1'b0;
    wide_word = m[0];
    path_hybrid = m[1];
    slow = m[0] ^ m[1];
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    enable = 1'b1;
    @(negedge clk);
  endtask : start

  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // takes the oldest note at every accepted word; a stray word is an error unless quiet is set
  always @(posedge clk) begin
    if (word_valid === 1'b1 && word_ack === 1'b1) begin
      if (exp_q.size() > 0) begin
        check(word, exp_q.pop_front());
      end else if (!quiet) begin
        check({15'h0, word_valid}, 16'h0000);
      end
    end
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      print_verdict;
    end
  end

  initial begin
    void'($urandom(32'hF3759AB9));
    for (int m = 0; m < 4; m++) begin
      start(m);
      if (m == 3) begin
        stuck(1'b1);
        check({15'h0, startup_done}, 16'h0000);
      end else begin
        send_good(16);
        check({15'h0, startup_done}, 16'h0001);
        track = 1'b1;
        send_good(16);
        drain;
        if (m == 0) begin
          quiet = 1'b1;
          repeat (32) send_byte(8'h01);
          repeat (2) @(negedge clk);
          check({15'h0, fail_stat}, 16'h0001);
          check({15'h0, startup_done}, 16'h0000);
          quiet = 1'b0;
          send_good(16);
          check({15'h0, startup_done}, 16'h0001);
          check({15'h0, fail_stat}, 16'h0001);
          track = 1'b1;
          send_good(8);
          drain;
        end else begin
          // leave run, then a fresh startup window must pass again
          enable = 1'b0;
          repeat (3) @(negedge clk);
          check({15'h0, startup_done}, 16'h0000);
          check({15'h0, word_valid}, 16'h0000);
          enable = 1'b1;
          send_good(16);
          check({15'h0, startup_done}, 16'h0001);
          stuck(m[0] ? 1'b0 : 1'b1);
        end
      end
      $display("test %0d done", m);
    end
    print_verdict;
  end
endmodule : tb_top
